// ### rtl/phs_pkg.sv
package phs_pkg;
  localparam logic [3:0] CMD_CFG_READ = 4'hA;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hB;
  localparam logic [3:0] CFG_DWORD_LIMIT = 4'h1;
  localparam logic [3:0] TGT_WAIT_LIMIT = 4'h1;

  typedef enum logic [1:0] {
    PHS_ROLE_IDLE,
    PHS_ROLE_INIT,
    PHS_ROLE_TGT
  } phs_role_t;

  typedef struct packed {
    logic o;
    logic oe;
  } phs_pin_t;
endpackage : phs_pkg

// ### rtl/phs_stop_gen.sv
`timescale 1ns/1ps
module phs_stop_gen
  import phs_pkg::*;
#(
  parameter logic [3:0] CFG_LIMIT = CFG_DWORD_LIMIT,
  parameter logic [3:0] WAIT_LIMIT = TGT_WAIT_LIMIT
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic active_in,
  input wire logic cfg_access_in,
  input wire logic phase_done_in,
  input wire logic init_wait_in,
  output logic stop_req_out
);
  logic [3:0] dword_cnt_ff;
  logic [3:0] wait_cnt_ff;
  logic stop_ff;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dword_cnt_ff <= 4'h0;
    end else if (clk_en_in) begin
      if (!active_in) begin
        dword_cnt_ff <= 4'h0;
      end else if (phase_done_in && dword_cnt_ff != 4'hF) begin
        dword_cnt_ff <= dword_cnt_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wait_cnt_ff <= 4'h0;
    end else if (clk_en_in) begin
      if (!active_in) begin
        wait_cnt_ff <= 4'h0;
      end else if (init_wait_in && wait_cnt_ff != 4'hF) begin
        wait_cnt_ff <= wait_cnt_ff + 4'h1;
      end
    end
  end

  // Stop only on config disconnect or initiator waits
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stop_ff <= 1'b0;
    end else if (clk_en_in) begin
      if (!active_in) begin
        stop_ff <= 1'b0;
      end else if ((cfg_access_in && (dword_cnt_ff + (phase_done_in ? 4'h1 : 4'h0)) >= CFG_LIMIT)
                   || (wait_cnt_ff + (init_wait_in ? 4'h1 : 4'h0)) >= WAIT_LIMIT) begin
        stop_ff <= 1'b1;
      end
    end
  end

  assign stop_req_out = stop_ff;
endmodule : phs_stop_gen

// ### rtl/phs_handshake.sv
`timescale 1ns/1ps
// Functional notes
// - Drive IRDY as initiator, input as target
// - IRDY high means initiator wait state
// - Phase completes when IRDY and TRDY low
// - Initiator continues until stop driven low, or frame high after a done phase
// - Sampled stop ends transaction next cycle
// - Target stops: config single dword, waits
// - Drive stop as target, else tristate
// - IDSEL config command claims device next cycle
// - All pins sampled/updated on rising edge
module phs_handshake
  import phs_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic init_start_in,
  input wire logic init_ready_in,
  input wire logic frame_n_in,
  input wire logic addr_phase_in,
  input wire logic [3:0] command_byte_enable_n_in,
  input wire logic init_dev_select_in,
  input wire logic initiator_ready_n_in,
  input wire logic target_ready_n_in,
  input wire logic stop_request_n_in,
  output logic initiator_ready_n_out,
  output logic initiator_ready_n_oe_out,
  output logic stop_request_n_out,
  output logic stop_request_n_oe_out,
  output logic device_select_n_out,
  output logic cfg_access_out,
  output logic phase_done_out,
  output logic init_terminated_out,
  output logic [1:0] role_out
);
  phs_role_t role_ff;
  phs_role_t nxt_role;
  phs_pin_t irdy_pin;
  phs_pin_t stop_pin;
  logic irdy_n_ff;
  logic idsel_ff;
  logic [3:0] cbe_ff;
  logic addr_ff;
  logic devsel_n_ff;
  logic phase_done_ff;
  logic term_ff;
  logic stop_seen_ff;
  logic cfg_hit;
  logic tgt_active;
  logic tgt_stop;
  logic tgt_done;
  logic [3:0] cmd_code;
  logic cmd_is_cfg;
  logic tgt_wait;
  logic nxt_devsel_n;
  logic nxt_irdy_n;
  logic nxt_stop_seen;
  logic nxt_term;
  logic nxt_phase_done;

  // Pins registered on the rising edge
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      idsel_ff <= 1'b0;
    end else if (clk_en_in) begin
      idsel_ff <= init_dev_select_in;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cbe_ff <= 4'hF;
    end else if (clk_en_in) begin
      cbe_ff <= command_byte_enable_n_in;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      addr_ff <= 1'b0;
    end else if (clk_en_in) begin
      addr_ff <= addr_phase_in;
    end
  end

  // Command decode, pins are active low
  assign cmd_code = ~cbe_ff;

  always_comb begin
    case (cmd_code)
      CMD_CFG_READ: cmd_is_cfg = 1'b1;
      CMD_CFG_WRITE: cmd_is_cfg = 1'b1;
      default: cmd_is_cfg = 1'b0;
    endcase
  end

  assign cfg_hit = addr_ff && idsel_ff && cmd_is_cfg;

  // Role next state
  always_comb begin
    nxt_role = role_ff;
    unique case (role_ff)
      PHS_ROLE_IDLE: begin
        if (init_start_in) begin
          nxt_role = PHS_ROLE_INIT;
        end else if (cfg_hit) begin
          nxt_role = PHS_ROLE_TGT;
        end
      end
      PHS_ROLE_INIT: begin
        if (stop_seen_ff || (frame_n_in && phase_done_ff)) begin
          nxt_role = PHS_ROLE_IDLE;
        end
      end
      PHS_ROLE_TGT: begin
        if (frame_n_in && initiator_ready_n_in) begin
          nxt_role = PHS_ROLE_IDLE;
        end
      end
      default: nxt_role = PHS_ROLE_IDLE;
    endcase
  end

  // Role tracking
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      role_ff <= PHS_ROLE_IDLE;
    end else if (clk_en_in) begin
      role_ff <= nxt_role;
    end
  end

  // Config claim: device select one clock after address phase
  assign nxt_devsel_n = !(cfg_hit && role_ff == PHS_ROLE_IDLE);

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      devsel_n_ff <= 1'b1;
    end else if (clk_en_in) begin
      devsel_n_ff <= nxt_devsel_n;
    end
  end

  // Initiator ready drive
  assign nxt_irdy_n = !(role_ff == PHS_ROLE_INIT && init_ready_in && !stop_seen_ff);

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irdy_n_ff <= 1'b1;
    end else if (clk_en_in) begin
      irdy_n_ff <= nxt_irdy_n;
    end
  end

  // Stop sampled as initiator, terminate next cycle
  assign nxt_stop_seen = role_ff == PHS_ROLE_INIT && !stop_request_n_in && !stop_seen_ff;
  assign nxt_term = stop_seen_ff;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stop_seen_ff <= 1'b0;
    end else if (clk_en_in) begin
      stop_seen_ff <= nxt_stop_seen;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      term_ff <= 1'b0;
    end else if (clk_en_in) begin
      term_ff <= nxt_term;
    end
  end

  // Data phase completion
  assign nxt_phase_done = role_ff != PHS_ROLE_IDLE && !initiator_ready_n_in && !target_ready_n_in;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase_done_ff <= 1'b0;
    end else if (clk_en_in) begin
      phase_done_ff <= nxt_phase_done;
    end
  end

  // Target side completion and initiator waits
  assign tgt_active = role_ff == PHS_ROLE_TGT;
  assign tgt_done = tgt_active && !initiator_ready_n_in && !target_ready_n_in;
  assign tgt_wait = tgt_active && initiator_ready_n_in && !frame_n_in;

  phs_stop_gen u_stop (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .active_in(tgt_active),
    .cfg_access_in(tgt_active),
    .phase_done_in(tgt_done),
    .init_wait_in(tgt_wait),
    .stop_req_out(tgt_stop)
  );

  // Pin drivers
  always_comb begin
    irdy_pin.o = irdy_n_ff;
    irdy_pin.oe = role_ff == PHS_ROLE_INIT;
  end

  always_comb begin
    stop_pin.o = !tgt_stop;
    stop_pin.oe = tgt_active;
  end

  assign initiator_ready_n_out = irdy_pin.o;
  assign initiator_ready_n_oe_out = irdy_pin.oe;
  assign stop_request_n_out = stop_pin.o;
  assign stop_request_n_oe_out = stop_pin.oe;
  assign device_select_n_out = devsel_n_ff;
  assign cfg_access_out = tgt_active;
  assign phase_done_out = phase_done_ff;
  assign init_terminated_out = term_ff;
  assign role_out = role_ff;
endmodule : phs_handshake

// ### test/phs_far_side.sv
`timescale 1ns/1ps
module phs_far_side (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic slow_in,
  input wire logic stop_cmd_in,
  output logic target_ready_n_out,
  output logic stop_request_n_out
);
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) target_ready_n_out <= 1'h1;
    else target_ready_n_out <= slow_in & ~target_ready_n_out;
  end
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) stop_request_n_out <= 1'h1;
    else stop_request_n_out <= ~stop_cmd_in;
  end
endmodule : phs_far_side

// ### test/phs_handshake_asserts.sv
`timescale 1ns/1ps
module phs_handshake_asserts
  import phs_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic init_start_in,
  input wire logic addr_phase_in,
  input wire logic [3:0] command_byte_enable_n_in,
  input wire logic init_dev_select_in,
  input wire logic initiator_ready_n_in,
  input wire logic target_ready_n_in,
  input wire logic stop_request_n_in,
  input wire logic initiator_ready_n_oe_out,
  input wire logic stop_request_n_out,
  input wire logic stop_request_n_oe_out,
  input wire logic device_select_n_out,
  input wire logic phase_done_out,
  input wire logic init_terminated_out,
  input wire logic [1:0] role_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_irdy_oe_role: assert property (initiator_ready_n_oe_out == (role_out == 2'h1))
    else $error("irdy enable");
  a_stop_oe_role: assert property (stop_request_n_oe_out == (role_out == 2'h2))
    else $error("stop enable");
  a_done_cause: assert property (phase_done_out |-> $past(!initiator_ready_n_in && !target_ready_n_in))
    else $error("done cause");
  a_stop_ends: assert property (role_out == 2'h1 && !stop_request_n_in |-> ##[1:2] role_out == 2'h0)
    else $error("stop end");
  a_term_pulse: assert property (role_out == 2'h1 && !stop_request_n_in |-> ##[1:3] init_terminated_out)
    else $error("term pulse");
  a_cfg_claim: assert property (addr_phase_in && init_dev_select_in && role_out == 2'h0 && !init_start_in
    && (command_byte_enable_n_in == ~CMD_CFG_READ || command_byte_enable_n_in == ~CMD_CFG_WRITE)
    |-> ##[1:2] !device_select_n_out) else $error("cfg claim");
  a_devsel_once: assert property (!device_select_n_out |=> device_select_n_out)
    else $error("devsel");
  a_stop_cause: assert property (stop_request_n_oe_out && $fell(stop_request_n_out)
    |-> phase_done_out || $past(initiator_ready_n_in)) else $error("stop");
  c_cfg: cover property (!device_select_n_out);
  c_term: cover property (init_terminated_out);
  c_tstop: cover property (stop_request_n_oe_out && !stop_request_n_out);
endmodule : phs_handshake_asserts
bind phs_handshake phs_handshake_asserts u_phs_handshake_asserts (.ref_clk_in(ref_clk_in),
  .sys_rst_in(sys_rst_in), .init_start_in(init_start_in), .addr_phase_in(addr_phase_in),
  .command_byte_enable_n_in(command_byte_enable_n_in), .init_dev_select_in(init_dev_select_in),
  .initiator_ready_n_in(initiator_ready_n_in), .target_ready_n_in(target_ready_n_in),
  .stop_request_n_in(stop_request_n_in), .initiator_ready_n_oe_out(initiator_ready_n_oe_out),
  .stop_request_n_out(stop_request_n_out), .stop_request_n_oe_out(stop_request_n_oe_out),
  .device_select_n_out(device_select_n_out), .phase_done_out(phase_done_out),
  .init_terminated_out(init_terminated_out), .role_out(role_out));

// ### test/phs_handshake_tb.sv
`timescale 1ns/1ps
module phs_handshake_tb
  import phs_pkg::*;
;
  logic ref_clk_in, sys_rst_in, clk_en_in, init_start_in, init_ready_in, frame_n_in, addr_phase_in;
  logic init_dev_select_in, far_slow, far_stop_cmd, bus_irdy_n, far_stop_n;
  logic initiator_ready_n_in, target_ready_n_in, stop_request_n_in, initiator_ready_n_out;
  logic initiator_ready_n_oe_out, stop_request_n_out, stop_request_n_oe_out, device_select_n_out;
  logic cfg_access_out, phase_done_out, init_terminated_out;
  logic [3:0] command_byte_enable_n_in;
  logic [1:0] role_out;
  int failures, comparisons;
  assign initiator_ready_n_in = initiator_ready_n_oe_out ? initiator_ready_n_out : bus_irdy_n;
  assign stop_request_n_in = stop_request_n_oe_out ? stop_request_n_out : far_stop_n;
  phs_handshake u_phs_handshake (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
    .init_start_in(init_start_in), .init_ready_in(init_ready_in), .frame_n_in(frame_n_in),
    .addr_phase_in(addr_phase_in), .command_byte_enable_n_in(command_byte_enable_n_in),
    .init_dev_select_in(init_dev_select_in), .initiator_ready_n_in(initiator_ready_n_in),
    .target_ready_n_in(target_ready_n_in), .stop_request_n_in(stop_request_n_in),
    .initiator_ready_n_out(initiator_ready_n_out), .initiator_ready_n_oe_out(initiator_ready_n_oe_out),
    .stop_request_n_out(stop_request_n_out), .stop_request_n_oe_out(stop_request_n_oe_out),
    .device_select_n_out(device_select_n_out), .cfg_access_out(cfg_access_out),
    .phase_done_out(phase_done_out), .init_terminated_out(init_terminated_out), .role_out(role_out));
  phs_far_side u_phs_far_side (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .slow_in(far_slow),
    .stop_cmd_in(far_stop_cmd), .target_ready_n_out(target_ready_n_in), .stop_request_n_out(far_stop_n));
  task give_verdict;
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task check(input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task step(input int n);
    @(negedge ref_clk_in);
    if (n > 40) begin
      failures++;
      give_verdict();
    end
  endtask : step
  task init_run;
    int n;
    clk_en_in = 0; init_start_in = 1; init_ready_in = 0; far_slow = 1; frame_n_in = 0;
    repeat (3) @(negedge ref_clk_in);
    check({role_out, initiator_ready_n_oe_out}, 4'h0);
    clk_en_in = 1;
    for (n = 0; role_out !== 2'h1; n++) step(n);
    init_start_in = 0;
    check({initiator_ready_n_oe_out, stop_request_n_oe_out}, 4'h2);
    repeat (2) @(negedge ref_clk_in);
    check({initiator_ready_n_out, phase_done_out}, 4'h2);
    init_ready_in = 1;
    for (n = 0; phase_done_out !== 1'h1; n++) step(n);
    check(role_out, 4'h1);
    check(initiator_ready_n_out, 4'h0);
    far_stop_cmd = 1;
    for (n = 0; init_terminated_out !== 1'h1; n++) step(n);
    check({role_out, initiator_ready_n_oe_out}, 4'h0);
    far_stop_cmd = 0; init_ready_in = 0; far_slow = 0; frame_n_in = 1;
    @(negedge ref_clk_in);
  endtask : init_run
  task cfg_run(input logic [3:0] cmd, input logic wt);
    int n;
    frame_n_in = 0; addr_phase_in = 1; init_dev_select_in = 1; command_byte_enable_n_in = ~cmd;
    @(negedge ref_clk_in);
    addr_phase_in = 0; init_dev_select_in = 0; command_byte_enable_n_in = 4'h0;
    for (n = 0; device_select_n_out !== 1'h0; n++) step(n);
    check({role_out, stop_request_n_oe_out, initiator_ready_n_oe_out}, 4'hA);
    check(cfg_access_out, 4'h1);
    bus_irdy_n = wt;
    for (n = 0; stop_request_n_out !== 1'h0; n++) step(n);
    check({stop_request_n_out, bus_irdy_n}, {3'h0, wt});
    frame_n_in = 1; bus_irdy_n = 1;
    for (n = 0; role_out !== 2'h0; n++) step(n);
    check(stop_request_n_oe_out, 4'h0);
  endtask : cfg_run
  initial begin
    ref_clk_in = 0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    sys_rst_in = 1; clk_en_in = 1; init_start_in = 0; init_ready_in = 0; frame_n_in = 1; addr_phase_in = 0;
    init_dev_select_in = 0; far_slow = 0; far_stop_cmd = 0; bus_irdy_n = 1; command_byte_enable_n_in = 4'hF;
    failures = 0; comparisons = 0;
    repeat (20) @(negedge ref_clk_in);
    sys_rst_in = 0;
    @(negedge ref_clk_in);
    check({role_out, initiator_ready_n_oe_out, stop_request_n_oe_out}, 4'h0);
    init_run();
    cfg_run(CMD_CFG_READ, 1'h0);
    cfg_run(CMD_CFG_WRITE, 1'h0);
    cfg_run(CMD_CFG_READ, 1'h1);
    give_verdict();
  end
endmodule : phs_handshake_tb
